// ---- core_event_stage.sv ----
// Purpose: Core event stage with system routing, fixed priority and nesting
// Assumes: Pin and foreign request inputs may be asynchronous and are synchronised here; exception and software requests arrive on this clock
// Notes: One event taken per save/enter sequence; returns drop the top level
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - Higher priority pending event is serviced first
// RULE2 - Higher priority may nest over active routines
// RULE3 - Five classes: emulation, reset, NMI, exception, interrupt
// RULE4 - Emulation event enters JTAG emulation mode
// RULE5 - Reset event resets the whole processor
// RULE6 - NMI from watchdog or NMI pin
// RULE7 - Exception taken before offending instruction retires
// RULE8 - Misalignment and undefined opcode raise exceptions
// RULE9 - Interrupts from pins, peripherals, software instruction
// RULE10 - Per-class return address captured, resumed on return
// RULE11 - Processor state saved to supervisor stack
// RULE12 - Peripheral requests routed onto general levels
// RULE13 - Nine general levels numbered 7 to 15
// RULE14 - Software should keep levels 14, 15
// RULE15 - Fixed priority map 0 to 15
// RULE16 - Default routing after reset, software reassignable
// RULE17 - Preempt only when strictly higher than active
// RULE18 - Masks gate levels 5 to 15 only
module core_event_stage
  import cep_pkg::*;
#(
  parameter int NUM_SRC = 8,
  parameter int ADDR_W = 32,
  parameter logic [4*NUM_SRC-1:0] DEFAULT_ROUTE = 32'hddcba987
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic emuReq,
  input wire logic nmiPin,
  input wire logic watchdogNmi,
  input wire logic resetReq,
  input wire logic misalignFault,
  input wire logic undefOpcode,
  input wire logic hwErrReq,
  input wire logic coreTimerReq,
  input wire logic swIntReq,
  input wire logic [3:0] swIntLevel,
  input wire logic [NUM_SRC-1:0] periphReq,
  input wire logic routeWrEn,
  input wire logic [$clog2(NUM_SRC)-1:0] routeWrSel,
  input wire logic [3:0] routeWrLevel,
  input wire logic maskWrEn,
  input wire logic [15:0] maskWrData,
  input wire logic [ADDR_W-1:0] currentPc,
  input wire logic retEvent,
  input wire logic stackAck,
  output logic eventTake,
  output logic [3:0] eventLevel,
  output logic [2:0] eventClass,
  output logic instrKill,
  output logic emuMode,
  output logic coreResetOut,
  output logic stackSaveReq,
  output logic [15:0] activeLevels,
  output logic [15:0] pendingLevels,
  output logic [ADDR_W-1:0] returnAddr
);
  // One source would leave the route select with no bits
  if (NUM_SRC < 2 || NUM_SRC > 64 || ADDR_W < 2)
  begin : g_bad_params
    $error("core_event_stage: unsupported parameters");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] emuS;
    logic [1:0] nmiS;
    logic [1:0] wdS;
    logic [1:0] rstS;
    logic [1:0] hweS;
    logic [1:0] tmrS;
    logic [NUM_SRC-1:0] per0;
    logic [NUM_SRC-1:0] per1;
    logic nmiPrev;
    logic [4*NUM_SRC-1:0] route;
    logic [15:0] mask;
    logic [15:0] pend;
    logic [15:0] active;
    cep_state_t st;
    logic [3:0] takeLvl;
    logic take;
    logic [2:0] cls;
    logic kill;
    logic emulation_event_slot;
    logic rstOut;
    logic save;
    logic [15:0][ADDR_W-1:0] retAddr;
    logic [ADDR_W-1:0] retOut;
  } cep_state_s_t;

  cep_state_s_t cur_ff;
  cep_state_s_t nxt_cur;

  function automatic logic [3:0] cepFirst(input logic [15:0] v);
    logic [3:0] r;
    r = LVL_GEN_LAST;
    for (int i = CEP_LEVELS - 1; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction

  function automatic cep_class_t cepClass(input logic [3:0] l);
    cep_class_t c;
    c = CLS_INT;
    if (l == LVL_EMU) c = CLS_EMU;
    else if (l == LVL_RST) c = CLS_RST;
    else if (l == LVL_NMI) c = CLS_NMI;
    else if (l == LVL_EXC) c = CLS_EXC;
    return c;
  endfunction

  logic [15:0] raise;
  logic [15:0] ready;
  logic [3:0] bestLvl;
  logic [3:0] actLvl;

  always_comb
  begin
    nxt_cur = cur_ff;
    raise = ZERO16;
    // Pin and foreign inputs pass two flops first
    nxt_cur.emuS = {cur_ff.emuS[0], emuReq};
    nxt_cur.nmiS = {cur_ff.nmiS[0], nmiPin};
    nxt_cur.wdS = {cur_ff.wdS[0], watchdogNmi};
    nxt_cur.rstS = {cur_ff.rstS[0], resetReq};
    nxt_cur.hweS = {cur_ff.hweS[0], hwErrReq};
    nxt_cur.tmrS = {cur_ff.tmrS[0], coreTimerReq};
    nxt_cur.per0 = periphReq;
    nxt_cur.per1 = cur_ff.per0;
    nxt_cur.nmiPrev = cur_ff.nmiS[1] | cur_ff.wdS[1];
    raise[LVL_EMU] = cur_ff.emuS[1]; // RULE3
    raise[LVL_RST] = cur_ff.rstS[1];
    raise[LVL_NMI] = (cur_ff.nmiS[1] | cur_ff.wdS[1]) & ~cur_ff.nmiPrev; // RULE6
    // Exceptions come from the pipeline on this clock, so no sync delay
    raise[LVL_EXC] = misalignFault | undefOpcode; // RULE8
    raise[LVL_HWERR] = cur_ff.hweS[1];
    raise[LVL_TMR] = cur_ff.tmrS[1];
    if (swIntReq && swIntLevel >= LVL_GEN_FIRST)
      raise[swIntLevel] = 1'b1; // RULE9
    for (int s = 0; s < NUM_SRC; s++)
      if (cur_ff.per1[s])
        raise[cur_ff.route[4*s +: 4]] = 1'b1; // RULE12 RULE13
    raise[LVL_RSVD] = 1'b0; // RULE15
    if (routeWrEn && routeWrLevel >= LVL_GEN_FIRST)
      nxt_cur.route[4*routeWrSel +: 4] = routeWrLevel; // RULE16
    if (maskWrEn)
      nxt_cur.mask = maskWrData | UNMASKABLE; // RULE18
    ready = cur_ff.pend & (cur_ff.mask | UNMASKABLE); // RULE18
    bestLvl = cepFirst(ready); // RULE1 RULE15
    actLvl = (cur_ff.active == ZERO16) ? LVL_GEN_LAST : cepFirst(cur_ff.active);
    nxt_cur.take = 1'b0;
    nxt_cur.kill = 1'b0;
    nxt_cur.rstOut = 1'b0;
    // Return: top active level retires, its address is presented
    if (retEvent && cur_ff.active != ZERO16)
    begin
      nxt_cur.active[actLvl] = 1'b0; // RULE10
      nxt_cur.retOut = cur_ff.retAddr[actLvl]; // RULE10
      if (actLvl == LVL_EMU)
        nxt_cur.emulation_event_slot = 1'b0;
    end
    unique case (cur_ff.st)
      ST_RUN:
        // Strictly higher priority only; ties wait for the return
        if (ready != ZERO16 && (cur_ff.active == ZERO16 || bestLvl < actLvl)) // RULE17 RULE2
        begin
          nxt_cur.takeLvl = bestLvl;
          nxt_cur.cls = cepClass(bestLvl); // RULE3
          nxt_cur.retAddr[bestLvl] = currentPc; // RULE10
          nxt_cur.kill = (bestLvl == LVL_EXC); // RULE7
          nxt_cur.save = 1'b1; // RULE11
          nxt_cur.st = ST_SAVE;
        end
      ST_SAVE:
        if (stackAck)
        begin
          nxt_cur.save = 1'b0;
          nxt_cur.st = ST_ENTER;
        end
      ST_ENTER:
      begin
        nxt_cur.take = 1'b1;
        nxt_cur.active[cur_ff.takeLvl] = 1'b1; // RULE2
        nxt_cur.pend[cur_ff.takeLvl] = 1'b0;
        if (cur_ff.takeLvl == LVL_EMU)
          nxt_cur.emulation_event_slot = 1'b1; // RULE4
        if (cur_ff.takeLvl == LVL_RST)
          nxt_cur.rstOut = 1'b1; // RULE5
        nxt_cur.st = ST_RUN;
      end
      default:
        nxt_cur.st = ST_RUN;
    endcase
    // New requests win over the clear on entry
    nxt_cur.pend = nxt_cur.pend | raise; // RULE1
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cur_ff <= '0;
      cur_ff.route <= DEFAULT_ROUTE; // RULE16
      cur_ff.mask <= MASK_RESET | UNMASKABLE;
      cur_ff.st <= ST_RUN;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign eventTake = cur_ff.take;
  assign eventLevel = cur_ff.takeLvl;
  assign eventClass = cur_ff.cls;
  assign instrKill = cur_ff.kill;
  assign emuMode = cur_ff.emulation_event_slot;
  assign coreResetOut = cur_ff.rstOut;
  assign stackSaveReq = cur_ff.save;
  assign activeLevels = cur_ff.active;
  assign pendingLevels = cur_ff.pend;
  assign returnAddr = cur_ff.retOut;
endmodule // core_event_stage
`default_nettype wire

// ---- cep_pkg.sv ----
// Purpose: Shared constants and types for the core event priority controller
// Assumes: 16 priority levels, 0 highest
// Notes: Routing defaults are per source, packed four bits each
package cep_pkg;
  localparam int CEP_LEVELS = 16;
  localparam int CEP_LVL_W = 4;
  localparam logic [3:0] LVL_EMU = 4'h0;
  localparam logic [3:0] LVL_RST = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXC = 4'h3;
  localparam logic [3:0] LVL_RSVD = 4'h4;
  localparam logic [3:0] LVL_HWERR = 4'h5;
  localparam logic [3:0] LVL_TMR = 4'h6;
  localparam logic [3:0] LVL_GEN_FIRST = 4'h7;
  localparam logic [3:0] LVL_GEN_LAST = 4'hf;
  localparam int CEP_GEN_COUNT = 9;
  // Levels that masking cannot block
  // Levels 0 to 4 carry no mask bit; exceptions must never be held off
  localparam logic [15:0] UNMASKABLE = 16'h001f;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Event classes
  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_EMU = 3'h1,
    CLS_RST = 3'h3,
    CLS_NMI = 3'h2,
    CLS_EXC = 3'h6,
    CLS_INT = 3'h7
  } cep_class_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SAVE = 2'h1,
    ST_ENTER = 2'h3
  } cep_state_t;
endpackage : cep_pkg

// ---- cep_props.sv ----
// Purpose: Port checks for the core event stage
// Assumes: One clock, sync active-high reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module cep_props
  import cep_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic stackAck,
  input wire logic eventTake,
  input wire logic [3:0] eventLevel,
  input wire logic [2:0] eventClass,
  input wire logic instrKill,
  input wire logic emuMode,
  input wire logic coreResetOut,
  input wire logic stackSaveReq,
  input wire logic [15:0] activeLevels
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence saveDone;
    stackSaveReq && stackAck;
  endsequence
  sequence saveStart;
    $rose(stackSaveReq);
  endsequence
  chk_take_pulse: assert property (eventTake |=> !eventTake) else $error("long take");
  chk_save_hold: assert property (stackSaveReq && !stackAck |=> stackSaveReq) else $error("save");
  chk_save_take: assert property (saveDone |-> ##2 eventTake) else $error("no take");
  chk_kill_exc: assert property (saveStart |-> instrKill == (eventClass == CLS_EXC))
    else $error("kill");
  chk_emu_mode: assert property (eventTake && eventClass == CLS_EMU |-> emuMode)
    else $error("emu");
  chk_rst_out: assert property (eventTake && eventClass == CLS_RST |-> coreResetOut)
    else $error("rst");
  chk_exc_level: assert property (eventTake && eventClass == CLS_EXC |-> eventLevel == LVL_EXC)
    else $error("exc lvl");
  chk_active_set: assert property (eventTake |-> activeLevels[eventLevel]) else $error("act");
  chk_nest_strict: assert property (saveStart |-> 16'(activeLevels << (4'hf - eventLevel)) == 16'h0)
    else $error("nest");
endmodule // cep_props
`default_nettype wire

// ---- cep_seq_model.sv ----
// Purpose: Sequencer stand-in for stack saves and the pc
// Assumes: Ack lag 0 to 3 cycles, set by the bench
// Notes: Ack drops once seen
`timescale 1ns/1ps
`default_nettype none
module cep_seq_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic stackSaveReq,
  input wire logic [1:0] lag,
  output logic stackAck,
  output logic [31:0] currentPc
);
  logic [1:0] waitCnt_ff;
  always_ff @(posedge core_clk)
  begin
    waitCnt_ff <= (stackSaveReq && !sys_rst) ? waitCnt_ff + 2'h1 : 2'h0;
    stackAck <= stackSaveReq && !stackAck && waitCnt_ff >= lag && !sys_rst;
    currentPc <= sys_rst ? 32'h0 : currentPc + 32'h4;
  end
endmodule // cep_seq_model
`default_nettype wire

// ---- core_event_priority_controller_tb_top.sv ----
// Purpose: Seeded random and directed bench
// Assumes: Sequencer model answers saves
// Notes: Routes, sw levels, ack lag random
`timescale 1ns/1ps
`default_nettype none
module core_event_priority_controller_tb_top;
  import cep_pkg::*;
  logic core_clk = 1'h0, sys_rst = 1'h1, retEvent = 1'h0, routeWrEn = 1'h0, maskWrEn = 1'h0;
  logic eventTake, instrKill, emuMode, coreResetOut, stackSaveReq, stackAck;
  logic [8:0] req = 9'h0;
  logic [7:0] periphReq = 8'h0;
  logic [2:0] routeWrSel = 3'h0, eventClass;
  logic [3:0] swIntLevel = 4'h7, routeWrLevel = 4'h7, eventLevel;
  logic [15:0] maskWrData = 16'h0, activeLevels, pendingLevels;
  logic [31:0] currentPc, returnAddr, pcPrev;
  logic [31:0] pcSaved [16];
  logic savePrev;
  logic [1:0] lag = 2'h0;
  int bad_count = 0, total_checks = 0, seed = 82;
  always #10 core_clk = ~core_clk;
  core_event_stage core_event_stage_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .emuReq(req[0]),
    .nmiPin(req[2]),
    .watchdogNmi(req[3]),
    .resetReq(req[1]),
    .misalignFault(req[4]),
    .undefOpcode(req[5]),
    .hwErrReq(req[6]),
    .coreTimerReq(req[7]),
    .swIntReq(req[8]),
    .swIntLevel(swIntLevel),
    .periphReq(periphReq),
    .routeWrEn(routeWrEn),
    .routeWrSel(routeWrSel),
    .routeWrLevel(routeWrLevel),
    .maskWrEn(maskWrEn),
    .maskWrData(maskWrData),
    .currentPc(currentPc),
    .retEvent(retEvent),
    .stackAck(stackAck),
    .eventTake(eventTake),
    .eventLevel(eventLevel),
    .eventClass(eventClass),
    .instrKill(instrKill),
    .emuMode(emuMode),
    .coreResetOut(coreResetOut),
    .stackSaveReq(stackSaveReq),
    .activeLevels(activeLevels),
    .pendingLevels(pendingLevels),
    .returnAddr(returnAddr)
  );
  cep_seq_model cep_seq_model_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .stackSaveReq(stackSaveReq),
    .lag(lag),
    .stackAck(stackAck),
    .currentPc(currentPc)
  );
  // Pc latched by the stage at the choice edge, kept per level
  always @(posedge core_clk)
  begin
    pcPrev <= currentPc;
    savePrev <= stackSaveReq;
    if (stackSaveReq && !savePrev)
      pcSaved[eventLevel] <= pcPrev;
  end
  function automatic logic [3:0] topLvl(logic [15:0] v);
    logic [3:0] r;
    r = 4'hf;
    for (int i = 15; i >= 0; i--)
      if (v[i])
        r = 4'(i);
    return r;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (e !== s)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, s);
      bad_count++;
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [6:0] xp(int k);
    logic [2:0] c[9] = '{CLS_EMU, CLS_RST, CLS_NMI, CLS_NMI, CLS_EXC, CLS_EXC, CLS_INT, CLS_INT,
      CLS_INT};
    logic [3:0] v[9] = '{LVL_EMU, LVL_RST, LVL_NMI, LVL_NMI, LVL_EXC, LVL_EXC, LVL_HWERR, LVL_TMR,
      swIntLevel};
    return {c[k], v[k]};
  endfunction
  task automatic wtake(logic [6:0] x);
    int n = 0;
    do
    begin
      @(posedge core_clk);
      #1 n++;
    end
    while (eventTake !== 1'h1 && n < 40);
    chk("take", {1'h1, x}, {eventTake, eventClass, eventLevel});
  endtask
  task automatic fire(int k);
    @(posedge core_clk) req[k] <= 1'h1;
    if (k inside {4, 5, 8})
      @(posedge core_clk) req[k] <= 1'h0;
    wtake(xp(k));
    req <= 9'h0;
  endtask
  // Extra pops absorb requests that re-pend from the sync tail
  task automatic drain();
    logic [3:0] lvl;
    logic popped;
    repeat (6)
    begin
      @(posedge core_clk) retEvent <= |activeLevels;
      @(posedge core_clk) retEvent <= 1'h0;
      popped = retEvent;
      lvl = topLvl(activeLevels);
      #1 if (popped) chk("retaddr", pcSaved[lvl], returnAddr);
      repeat (8) @(posedge core_clk);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'h0;
    periphReq <= 8'h1;
    repeat (12) @(posedge core_clk);
    #1 chk("masked", 16'h0080, pendingLevels | activeLevels);
    // Exceptions carry no mask bit, so this is taken while level 7 waits
    fire(4);
    drain();
    maskWrData <= 16'hffff;
    @(posedge core_clk) maskWrEn <= 1'h1;
    @(posedge core_clk) maskWrEn <= 1'h0;
    wtake({CLS_INT, LVL_GEN_FIRST});
    periphReq <= 8'h80;
    fire(7);
    repeat (12) @(posedge core_clk);
    #1 chk("nest", 16'h20c0, activeLevels | (pendingLevels & 16'h2000));
    periphReq <= 8'h0;
    drain();
    req <= 9'h110;
    swIntLevel <= 4'he;
    @(posedge core_clk) req <= 9'h0;
    wtake({CLS_EXC, LVL_EXC});
    drain();
    for (int r = 0; r < 8; r++)
    begin
      lag <= 2'($random(seed));
      swIntLevel <= 4'h7 + 4'({$random(seed)} % 9);
      routeWrSel <= 3'($random(seed));
      routeWrLevel <= 4'h7 + 4'({$random(seed)} % 7);
      @(posedge core_clk) routeWrEn <= 1'h1;
      @(posedge core_clk) routeWrEn <= 1'h0;
      periphReq[routeWrSel] <= 1'h1;
      wtake({CLS_INT, routeWrLevel});
      periphReq <= 8'h0;
      drain();
      fire(8);
      drain();
    end
    for (int i = 8; i >= 0; i--)
    begin
      fire(i);
      drain();
    end
    #1 chk("idle", 32'h0, {15'h0, emuMode, pendingLevels | activeLevels});
    report_and_stop();
  end
  initial
  begin
    #200000 bad_count++;
    report_and_stop();
  end
endmodule // core_event_priority_controller_tb_top
bind core_event_stage cep_props cep_props_inst (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .stackAck(stackAck),
  .eventTake(eventTake),
  .eventLevel(eventLevel),
  .eventClass(eventClass),
  .instrKill(instrKill),
  .emuMode(emuMode),
  .coreResetOut(coreResetOut),
  .stackSaveReq(stackSaveReq),
  .activeLevels(activeLevels)
);
`default_nettype wire
